// ### logic/sequenced_multiplier_divider.sv
// Purpose: Time-sequenced two's complement multiplier/divider on a shared bus
// Assumes: Controller drives instr_code, load_b and bus; pins are asynchronous
// Notes:   Bus is split into in, out and output enable (low while driving)
// Contract
// - Integer mode weights every least significant bit as one.
// - Fraction mode: top bit weighs minus one, point right of it.
// - Plain fraction product lsb is zero unless addend brings a one.
// - Mode is chosen at sequence start by code 6 or 5, then held.
// - Multiply round adds top bit of lower half to upper, clears lower.
// - Rounding happens only at the end of an operation.
// - Divide round forces quotient lsb to one unless remainder zero.
// - Overflow clears before an operation and sets on out-of-range result.
// - Fraction multiply-accumulate overflows outside minus one to almost one.
// - Simple multiply overflows only when both operands are most negative.
// - Fraction divide overflows when quotient leaves single-length range.
// - Three-bit code decoded per sequencer state as the transition table.
// - Accumulation adds the previous double result; old operand is reused.
// - Multiplicand comes from the first rank of the operand register.
// - Scaled accumulate adds previous upper half, sign-extended, at lsb.
// - Single lower-half addend or dividend is sign-extended.
// - Narrow variant multiplies four cycles sooner.
// - Narrow variant divides eight cycles sooner.
// - Fraction divide finishes one cycle before integer divide.
// - Reads give upper half then lower; repeated initial reads alternate.
// - Holding read returns to the initial state within 21 or 13 clocks.
// - Without a new operand load, the previous operand is used.
`timescale 1ns/1ps
module sequenced_multiplier_divider
  import muldiv_pkg::*;
#(
  parameter int W = WIDE_BITS
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [2:0]   instr_code,
  input  wire logic         load_b,
  input  wire logic [W-1:0] bus_in,
  output logic      [W-1:0] bus_out,
  output logic              bus_oe_b,
  output logic              overflow
);

  localparam int                  D       = 2 * W;
  localparam logic [CNT_BITS-1:0] CNT_ONE = CNT_BITS'(1);

  typedef struct packed {
    seq_state_t          st;
    logic [CNT_BITS-1:0] cnt;
    logic                frac;
    logic [W-1:0]        operand_first_rank;
    logic [W-1:0]        xw;
    logic [W-1:0]        y;
    logic [W-1:0]        z;
    logic [W-1:0]        w;
    logic [W-1:0]        opz;
    logic [W-1:0]        opw;
    logic [D-1:0]        addend;
    logic [D-1:0]        dividend;
    logic                neg;
    logic                is_div;
    logic                simple;
    logic                rsel;
    logic [W-1:0]        bus_out;
    logic                bus_oe_b;
    logic                ovf;
  } core_t;

  localparam core_t Q_RST = '{st: ST_INIT, bus_oe_b: 1'b1, default: '0};

  function automatic logic [D-1:0] sext(input logic [W-1:0] v);
    sext = {{W{v[W-1]}}, v};
  endfunction : sext

  core_t        q;
  core_t        d;
  logic [W+3:0] pins_s;
  logic [2:0]   code;
  logic         act;
  logic [W-1:0] bus_s;
  logic [W-1:0] alu_hi;
  logic [W-1:0] alu_lo;
  logic         alu_ovf;
  logic         start_mul;
  logic         start_div;
  logic         acc;
  logic [D-1:0] addend_v;
  logic [D-1:0] dividend_v;

  pin_sync #(
    .WIDTH   (W + 4),
    .RST_VAL ({1'b1, 3'h7, {W{1'b0}}})
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   ({load_b, instr_code, bus_in}),
    .sync_out (pins_s)
  );

  assign act   = ~pins_s[W+3];
  assign code  = pins_s[W+2:W];
  assign bus_s = pins_s[W-1:0];

  muldiv_alu #(.W(W)) u_alu (
    .x        (q.xw),
    .y        (q.y),
    .addend   (q.addend),
    .dividend (q.dividend),
    .frac     (q.frac),
    .neg      (q.neg),
    .is_div   (q.is_div),
    .simple   (q.simple),
    .res_hi   (alu_hi),
    .res_lo   (alu_lo),
    .ovf      (alu_ovf)
  );

  always_comb begin
    d          = q;
    d.bus_oe_b = 1'b1;
    start_mul  = 1'b0;
    start_div  = 1'b0;
    acc        = code[1];
    addend_v   = '0;
    dividend_v = {q.z, q.w};
    if ((q.st == ST_MUL) || (q.st == ST_DIV)) begin
      // Code and strobe are ignored while the core counts
      if (q.cnt == CNT_ONE) begin
        d.z    = alu_hi;
        d.w    = alu_lo;
        d.ovf  = alu_ovf;
        d.rsel = 1'b0;
        d.st   = (q.st == ST_MUL) ? ST_END_MUL : ST_END_DIV;
      end else begin
        d.cnt = q.cnt - CNT_ONE;
      end
    end else if (act) begin
      case (code)
        CODE_MCLR_POS, CODE_MCLR_NEG, CODE_MACC_POS, CODE_MACC_NEG: begin
          start_mul = 1'b1;
          case (q.st)
            ST_GOT_Z: addend_v = acc ? sext(q.z) : {q.opz, {W{1'b0}}};
            ST_GOT_W: addend_v = acc ? sext(q.opw) : {q.opz, q.opw};
            default:  addend_v = acc ? {q.z, q.w} : '0;
          endcase
        end
        CODE_DIVIDE: begin
          start_div = 1'b1;
          case (q.st)
            ST_GOT_X: dividend_v = sext(q.w);
            ST_GOT_Z: dividend_v = {q.opz, bus_s};
            ST_GOT_W: dividend_v = {q.opz, q.opw};
            default:  dividend_v = {q.z, q.w};
          endcase
        end
        CODE_LOAD_FRAC: begin
          case (q.st)
            ST_INIT: begin
              d.operand_first_rank = bus_s;
              d.frac               = 1'b1;
              d.st                 = ST_GOT_X;
            end
            ST_END_MUL: begin
              d.z    = q.z + {{(W-1){1'b0}}, q.w[W-1]};
              d.w    = '0;
              d.rsel = 1'b0;
              d.st   = ST_INIT;
            end
            ST_END_DIV: begin
              d.z    = {q.z[W-1:1], q.z[0] | (q.w != '0)};
              d.w    = '0;
              d.rsel = 1'b0;
              d.st   = ST_INIT;
            end
            ST_GOT_X: begin
              start_div  = 1'b1;
              dividend_v = sext(q.z);
            end
            ST_GOT_Z: begin
              start_div  = 1'b1;
              dividend_v = sext(q.opz);
            end
            default: begin
              start_div  = 1'b1;
              dividend_v = sext(q.opw);
            end
          endcase
        end
        CODE_LOAD_INT: begin
          case (q.st)
            ST_GOT_X: begin
              d.opz = bus_s;
              d.st  = ST_GOT_Z;
            end
            ST_GOT_Z: begin
              d.opw = bus_s;
              d.st  = ST_GOT_W;
            end
            default: begin
              // Mode is only chosen at the start of a sequence
              if (q.st == ST_INIT) begin
                d.frac = 1'b0;
              end
              d.operand_first_rank = bus_s;
              d.st                 = ST_GOT_X;
            end
          endcase
        end
        default: begin
          // Read breaks any loading sequence and returns to the initial state
          d.bus_oe_b = 1'b0;
          if ((q.st == ST_INIT) && q.rsel) begin
            d.bus_out = q.w;
            d.rsel    = 1'b0;
          end else begin
            d.bus_out = q.z;
            d.rsel    = 1'b1;
          end
          d.st = ST_INIT;
        end
      endcase
    end
    if (start_mul) begin
      d.y      = bus_s;
      d.xw     = q.operand_first_rank;
      d.neg    = code[0];
      d.addend = addend_v;
      d.simple = !acc && (q.st != ST_GOT_Z) && (q.st != ST_GOT_W);
      d.is_div = 1'b0;
      d.ovf    = 1'b0;
      d.cnt    = mul_cycles(W);
      d.st     = ST_MUL;
    end
    if (start_div) begin
      d.xw       = q.operand_first_rank;
      d.dividend = dividend_v;
      d.is_div   = 1'b1;
      d.ovf      = 1'b0;
      d.cnt      = div_cycles(W, q.frac);
      d.st       = ST_DIV;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign bus_out  = q.bus_out;
  assign bus_oe_b = q.bus_oe_b;
  assign overflow = q.ovf;

  logic step_ok;
  assign step_ok = act && (q.st != ST_MUL) && (q.st != ST_DIV);

  sequence mul_run_s;
    (q.st == ST_MUL) [*8];
  endsequence

  sequence mul_done_s;
    q.st == ST_END_MUL;
  endsequence

  property mul_len_p;
    @(posedge clk) disable iff (!rst_b)
      $rose(q.st == ST_MUL) |-> mul_run_s ##1 mul_done_s;
  endproperty

  AST_MUL_LEN: assert property (mul_len_p)
    else $error("multiply did not take eight cycles");

  AST_DIV_INT_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(q.st == ST_DIV) && !q.frac) |-> ##20 (q.st == ST_END_DIV))
    else $error("integer divide did not take twenty cycles");

  AST_DIV_FRAC_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(q.st == ST_DIV) && q.frac) |-> ##19 (q.st == ST_END_DIV))
    else $error("fraction divide did not take nineteen cycles");

  AST_OVF_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(q.st == ST_MUL) || $rose(q.st == ST_DIV) |-> !overflow)
    else $error("overflow not cleared at operation start");

  AST_BUS_ONLY_READ: assert property (@(posedge clk) disable iff (!rst_b)
    !bus_oe_b |-> $past(step_ok && (code == CODE_READ)))
    else $error("bus driven outside a read step");

  AST_READ_Z_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
    (step_ok && (code == CODE_READ) && (q.st != ST_INIT)) |=> (bus_out == $past(q.z)))
    else $error("first read did not give the upper half");

  AST_READ_HOME: assert property (@(posedge clk) disable iff (!rst_b)
    (step_ok && (code == CODE_READ)) |=> (q.st == ST_INIT))
    else $error("read did not return to initial state");

  AST_ROUND_MUL: assert property (@(posedge clk) disable iff (!rst_b)
    (act && (q.st == ST_END_MUL) && (code == CODE_LOAD_FRAC)) |=>
      (q.w == '0) && (q.st == ST_INIT) && (q.z == $past(q.z) + $past(q.w[W-1])))
    else $error("multiply rounding wrong");

  AST_ROUND_DIV: assert property (@(posedge clk) disable iff (!rst_b)
    (act && (q.st == ST_END_DIV) && (code == CODE_LOAD_FRAC)) |=>
      (q.w == '0) && (q.st == ST_INIT) && (q.z[0] == ($past(q.z[0]) || ($past(q.w) != '0))))
    else $error("divide rounding wrong");

  AST_NO_MID_ROUND: assert property (@(posedge clk) disable iff (!rst_b)
    (act && (q.st == ST_GOT_X) && (code == CODE_LOAD_FRAC)) |=> (q.st == ST_DIV))
    else $error("rounding taken in mid loading");

  AST_MODE_HELD: assert property (@(posedge clk) disable iff (!rst_b)
    (q.st != ST_INIT) |=> $stable(q.frac))
    else $error("mode changed inside a sequence");

  AST_X_REUSED: assert property (@(posedge clk) disable iff (!rst_b)
    (act && (q.st == ST_INIT) && (code == CODE_MCLR_POS)) |=> (q.xw == $past(q.operand_first_rank)))
    else $error("previous operand not used");

  AST_FRAC_LSB: assert property (@(posedge clk) disable iff (!rst_b)
    ((q.st == ST_MUL) && (q.cnt == CNT_ONE) && q.frac && !q.addend[0]) |=> (q.w[0] == 1'b0))
    else $error("fraction product lsb not zero");

endmodule : sequenced_multiplier_divider

// ### logic/muldiv_pkg.sv
// Purpose: Shared codes, states and cycle counts of the sequenced multiplier/divider
// Assumes: One clock; codes and states are three bits wide
// Notes:   Cycle counts are derived from the operand width
package muldiv_pkg;

  typedef enum logic [2:0] {
    ST_INIT    = 3'h0,
    ST_GOT_X   = 3'h1,
    ST_GOT_Z   = 3'h2,
    ST_GOT_W   = 3'h3,
    ST_MUL     = 3'h4,
    ST_DIV     = 3'h5,
    ST_END_MUL = 3'h6,
    ST_END_DIV = 3'h7
  } seq_state_t;

  localparam logic [2:0] CODE_MCLR_POS  = 3'h0;
  localparam logic [2:0] CODE_MCLR_NEG  = 3'h1;
  localparam logic [2:0] CODE_MACC_POS  = 3'h2;
  localparam logic [2:0] CODE_MACC_NEG  = 3'h3;
  localparam logic [2:0] CODE_DIVIDE    = 3'h4;
  localparam logic [2:0] CODE_LOAD_FRAC = 3'h5;
  localparam logic [2:0] CODE_LOAD_INT  = 3'h6;
  localparam logic [2:0] CODE_READ      = 3'h7;

  localparam int WIDE_BITS       = 16;
  localparam int MUL_CYC_DIVISOR = 2;
  localparam int DIV_EXTRA_CYC   = 4;
  localparam int FRAC_DIV_SAVING = 1;
  localparam int CNT_BITS        = 6;

  // Multiply takes n/2 periods, divide n+4, fractional divide one fewer
  function automatic logic [CNT_BITS-1:0] mul_cycles(input int n);
    mul_cycles = CNT_BITS'(n / MUL_CYC_DIVISOR);
  endfunction : mul_cycles

  function automatic logic [CNT_BITS-1:0] div_cycles(input int n, input logic frac);
    div_cycles = CNT_BITS'(n + DIV_EXTRA_CYC - (frac ? FRAC_DIV_SAVING : 0));
  endfunction : div_cycles

endpackage : muldiv_pkg

// ### logic/pin_sync.sv
// Purpose: Two-flop synchroniser for the pins of the bus and control field
// Assumes: Pins change asynchronously to clk
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH   = 20,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d.s1 = pin_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;

endmodule : pin_sync

// ### logic/muldiv_alu.sv
// Purpose: Combinational multiply-accumulate and divide core
// Assumes: Operands are two's complement; results sampled at end of count
// Notes:   Fraction scaling shifts the product left by one place
`timescale 1ns/1ps
module muldiv_alu #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]   x,
  input  wire logic [W-1:0]   y,
  input  wire logic [2*W-1:0] addend,
  input  wire logic [2*W-1:0] dividend,
  input  wire logic           frac,
  input  wire logic           neg,
  input  wire logic           is_div,
  input  wire logic           simple,
  output logic      [W-1:0]   res_hi,
  output logic      [W-1:0]   res_lo,
  output logic                ovf
);

  localparam int D = 2 * W;

  logic signed [D+1:0] xe;
  logic signed [D+1:0] ye;
  logic signed [D+1:0] prod;
  logic signed [D+1:0] sum;
  logic signed [D+1:0] dn;
  logic signed [D+1:0] dv;
  logic signed [D+1:0] quo;
  logic signed [D+1:0] rem;
  logic                both_min;
  logic                mul_ovf;
  logic                div_ovf;

  always_comb begin
    xe       = $signed({{(D+2-W){x[W-1]}}, x});
    ye       = $signed({{(D+2-W){y[W-1]}}, y});
    both_min = (x == {1'b1, {(W-1){1'b0}}}) && (y == {1'b1, {(W-1){1'b0}}});
    // Integer weighting: lsb counts one
    prod = xe * ye;
    if (frac) begin
      // Binary point after the sign, so the product moves up one place
      prod = prod <<< 1;
    end
    if (neg) begin
      prod = -prod;
    end
    sum     = prod + $signed({{2{addend[D-1]}}, addend});
    mul_ovf = (sum[D+1:D-1] != 3'b000) && (sum[D+1:D-1] != 3'b111);
    if (simple) begin
      mul_ovf = both_min;
    end
    dn = $signed({{2{dividend[D-1]}}, dividend});
    dv = xe;
    if (frac) begin
      dv = dv <<< 1;
    end
    if (dv == '0) begin
      quo     = '0;
      rem     = '0;
      div_ovf = 1'b1;
    end else begin
      // Truncating divide keeps the remainder sign of the dividend
      quo     = dn / dv;
      rem     = dn % dv;
      div_ovf = (quo[D+1:W-1] != '0) && (quo[D+1:W-1] != '1);
    end
    if (frac && (dv != '0)) begin
      rem = rem >>> 1;
    end
    if (is_div) begin
      res_hi = quo[W-1:0];
      res_lo = rem[W-1:0];
      ovf    = div_ovf;
    end else begin
      res_hi = sum[D-1:W];
      res_lo = sum[W-1:0];
      ovf    = mul_ovf;
    end
  end

endmodule : muldiv_alu

// ### test/host_ctrl.sv
// Purpose: Controller model driving code, strobe and bus pins of the multiplier/divider
// Assumes: Pins change a fixed small delay after the rising clock edge
// Notes:   A released bus shows a changing level, since it has no pull
`timescale 1ns/1ps
module host_ctrl
  import muldiv_pkg::*;
#(
  parameter int W = WIDE_BITS
) (
  input  wire logic         clk,
  output logic [2:0]        instr_code,
  output logic              load_b,
  output logic [W-1:0]      bus_drv
);
  logic [W-1:0] last_q;

  initial begin
    instr_code = CODE_READ;
    load_b     = 1'b1;
    bus_drv    = '0;
    last_q     = '0;
  end

  // Code and data change together and hold for the whole step
  task automatic step(input logic [2:0] code, input logic [W-1:0] data);
    @(posedge clk);
    #2ns;
    instr_code = code;
    load_b     = 1'b0;
    bus_drv    = data;
    last_q     = data;
  endtask : step

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      #2ns;
      load_b  = 1'b1;
      bus_drv = ~last_q;
      last_q  = ~last_q;
    end
  endtask : idle

  // Bus not driven by us during a read
  task automatic read_step();
    @(posedge clk);
    #2ns;
    instr_code = CODE_READ;
    load_b     = 1'b0;
    bus_drv    = ~last_q;
    last_q     = ~last_q;
  endtask : read_step
endmodule : host_ctrl

// ### test/testbench.sv
// Purpose: Self-checking bench of the sequenced multiplier/divider
// Assumes: Controller model drives pins; results awaited by holding read
// Notes:   Codes are ignored while a count runs, so read may be held early
`timescale 1ns/1ps
module testbench;
  import muldiv_pkg::*;
  localparam int W     = WIDE_BITS;
  localparam int BOUND = 64;
  logic         clk;
  logic         rst_b;
  logic [2:0]   instr_code;
  logic         load_b;
  logic [W-1:0] bus_drv;
  logic [W-1:0] bus_in;
  logic [W-1:0] bus_out;
  logic         bus_oe_b;
  logic         overflow;
  logic [W-1:0] rd_z;
  logic [W-1:0] rd_w;
  logic [W-1:0] rd_z2;
  logic         rd_ovf;
  int           rd_cyc;
  int           cyc_f;
  int           n_fail;
  int           checked;

  // Wire level seen at the bus pins
  assign bus_in = bus_oe_b ? bus_drv : bus_out;

  sequenced_multiplier_divider #(.W(W)) u_sequenced_multiplier_divider (
    .clk(clk), .rst_b(rst_b), .instr_code(instr_code), .load_b(load_b),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_b(bus_oe_b), .overflow(overflow));

  host_ctrl #(.W(W)) u_host_ctrl (
    .clk(clk), .instr_code(instr_code), .load_b(load_b), .bus_drv(bus_drv));

  initial clk = 1'b0;
  always #12.5ns clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [31:0] prod(input logic frac, input logic neg,
                                       input logic [W-1:0] x, input logic [W-1:0] y);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    if (neg) begin
      p = -p;
    end
    prod = frac ? (p <<< 1) : p;
  endfunction : prod

  // Upper half, lower half, then upper again
  task automatic get_result();
    rd_cyc = 0;
    do begin
      u_host_ctrl.read_step();
      rd_cyc++;
    end while (bus_oe_b !== 1'b0 && rd_cyc < BOUND);
    if (bus_oe_b !== 1'b0) begin
      n_fail++;
      $display("ERROR bus_oe_b expected 0 seen %b", bus_oe_b);
      end_of_test();
    end
    rd_z   = bus_out;
    rd_ovf = overflow;
    u_host_ctrl.read_step();
    rd_w = bus_out;
    u_host_ctrl.read_step();
    rd_z2 = bus_out;
    u_host_ctrl.idle(4);
  endtask : get_result

  task automatic t_mul(input logic frac, input logic neg, input logic [W-1:0] x,
                       input logic [W-1:0] y, input int gap);
    logic [31:0] p;
    logic        ovf;
    p   = prod(frac, neg, x, y);
    ovf = (x == 16'h8000) && (y == 16'h8000);
    u_host_ctrl.step(frac ? CODE_LOAD_FRAC : CODE_LOAD_INT, x);
    u_host_ctrl.idle(gap);
    u_host_ctrl.step(neg ? CODE_MCLR_NEG : CODE_MCLR_POS, y);
    check("bus_oe_b loading", 1, bus_oe_b);
    get_result();
    check("overflow", ovf, rd_ovf);
    if (!ovf) begin
      check("mul z", p[31:16], rd_z);
      check("mul w", p[15:0], rd_w);
      check("mul z again", p[31:16], rd_z2);
      if (frac) begin
        check("mul w lsb", 0, rd_w[0]);
      end
    end
    $display("test mul done");
  endtask : t_mul

  task automatic t_round(input logic [W-1:0] x, input logic [W-1:0] y);
    logic [31:0] p;
    p = prod(1'b1, 1'b0, x, y);
    u_host_ctrl.step(CODE_LOAD_FRAC, x);
    u_host_ctrl.step(CODE_MCLR_POS, y);
    u_host_ctrl.idle(16);
    u_host_ctrl.step(CODE_LOAD_FRAC, '0);
    get_result();
    check("round z", p[31:16] + p[15], rd_z);
    check("round w", 0, rd_w);
    $display("test round done");
  endtask : t_round

  task automatic t_acc(input logic frac, input logic neg, input logic [W-1:0] x,
                       input logic [W-1:0] y1, input logic [W-1:0] y2);
    logic [31:0] p1;
    logic [31:0] p2;
    logic [32:0] s;
    p1 = prod(frac, 1'b0, x, y1);
    p2 = prod(frac, neg, x, y2);
    s  = {p1[31], p1} + {p2[31], p2};
    u_host_ctrl.step(frac ? CODE_LOAD_FRAC : CODE_LOAD_INT, x);
    u_host_ctrl.step(CODE_MCLR_POS, y1);
    u_host_ctrl.idle(16);
    u_host_ctrl.step(neg ? CODE_MACC_NEG : CODE_MACC_POS, y2);
    get_result();
    check("acc overflow", s[32] ^ s[31], rd_ovf);
    if (s[32] == s[31]) begin
      check("acc z", s[31:16], rd_z);
      check("acc w", s[15:0], rd_w);
    end
    $display("test acc done");
  endtask : t_acc

  // Integer multiply with an operand added in after loading X, Z and maybe W
  task automatic t_add(input logic [2:0] code, input logic load_w, input logic [W-1:0] x,
                       input logic [W-1:0] z, input logic [W-1:0] w, input logic [W-1:0] y,
                       input logic [31:0] add);
    logic [31:0] p;
    p = prod(1'b0, code[0], x, y) + add;
    u_host_ctrl.step(CODE_LOAD_INT, x);
    u_host_ctrl.step(CODE_LOAD_INT, z);
    if (load_w) begin
      u_host_ctrl.step(CODE_LOAD_INT, w);
    end
    u_host_ctrl.step(code, y);
    get_result();
    check("add overflow", 0, rd_ovf);
    check("add z", p[31:16], rd_z);
    check("add w", p[15:0], rd_w);
    $display("test add done");
  endtask : t_add

  // Multiply straight from the initial state with the X kept from before
  task automatic t_const(input logic [W-1:0] x_prev, input logic [W-1:0] y);
    logic [31:0] p;
    p = prod(1'b0, 1'b0, x_prev, y);
    u_host_ctrl.step(CODE_MCLR_POS, y);
    get_result();
    check("const z", p[31:16], rd_z);
    check("const w", p[15:0], rd_w);
    $display("test const done");
  endtask : t_const

  task automatic t_div(input logic frac, input logic single, input logic rnd,
                       input logic exp_ovf, input logic [W-1:0] z,
                       input logic [W-1:0] w, input logic [W-1:0] x);
    logic signed [31:0] dvd;
    logic signed [31:0] q;
    logic signed [31:0] r;
    dvd = single ? 32'($signed(w)) : $signed({z, w});
    q   = dvd / $signed(x);
    r   = dvd % $signed(x);
    if (rnd) begin
      q[0] = q[0] | (r != 0);
      r    = 0;
    end
    u_host_ctrl.step(frac ? CODE_LOAD_FRAC : CODE_LOAD_INT, x);
    if (single) begin
      u_host_ctrl.step(CODE_LOAD_INT, '0);
      u_host_ctrl.step(CODE_LOAD_INT, w);
      u_host_ctrl.step(CODE_LOAD_FRAC, '0);
    end else begin
      u_host_ctrl.step(CODE_LOAD_INT, z);
      u_host_ctrl.step(CODE_DIVIDE, w);
    end
    if (rnd) begin
      u_host_ctrl.idle(32);
      u_host_ctrl.step(CODE_LOAD_FRAC, '0);
    end
    get_result();
    check("div overflow", exp_ovf, rd_ovf);
    if (!frac && !exp_ovf) begin
      check("quotient", q[15:0], rd_z);
      check("remainder", r[15:0], rd_w);
    end
    $display("test div done");
  endtask : t_div

  initial begin
    n_fail  = 0;
    checked = 0;
    rst_b   = 1'b0;
    repeat (10) @(posedge clk);
    check("bus_oe_b reset", 1, bus_oe_b);
    check("overflow reset", 0, overflow);
    #2ns;
    rst_b = 1'b1;
    t_mul(1'b0, 1'b0, 16'hFFFD, 16'h0007, 0);
    t_mul(1'b1, 1'b0, 16'h4000, 16'h6000, 3);
    t_mul(1'b0, 1'b1, 16'h1234, 16'h0101, 0);
    t_mul(1'b1, 1'b1, 16'hC000, 16'h3000, 0);
    t_mul(1'b0, 1'b0, 16'h8000, 16'h8000, 0);
    t_mul(1'b1, 1'b0, 16'h8000, 16'h8000, 0);
    t_mul(1'b0, 1'b0, 16'h8000, 16'h7FFF, 0);
    t_round(16'h4001, 16'h5003);
    t_acc(1'b0, 1'b1, 16'h0123, 16'h0456, 16'hFFF9);
    t_acc(1'b1, 1'b0, 16'h7FFF, 16'h7FFF, 16'h7FFF);
    t_add(CODE_MCLR_POS, 1'b1, 16'h0010, 16'h0002, 16'h8001, 16'h0003, 32'h0002_8001);
    t_add(CODE_MACC_POS, 1'b0, 16'h0010, 16'h1234, 16'h0000, 16'h0003, 32'h0000_0002);
    t_add(CODE_MACC_NEG, 1'b1, 16'h0010, 16'h0000, 16'hFFF0, 16'h0003, 32'hFFFF_FFF0);
    t_add(CODE_MCLR_NEG, 1'b0, 16'h0010, 16'h0005, 16'h0000, 16'h0003, 32'h0005_0000);
    t_const(16'h0010, 16'h0100);
    t_div(1'b0, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16'hFF9C, 16'h0007);
    t_div(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h8003, 16'h0100);
    t_div(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h03E8, 16'h0007);
    t_div(1'b1, 1'b0, 1'b0, 1'b1, 16'h4000, 16'h0000, 16'h2000);
    cyc_f = rd_cyc;
    t_div(1'b0, 1'b0, 1'b0, 1'b1, 16'h4000, 16'h0000, 16'h2000);
    check("divide length gap", 1, rd_cyc - cyc_f);
    end_of_test();
  end
endmodule : testbench
